// ### rtl/ring_counter_compare_unit.sv
// per-axis ring position counters and four compare channels
// assumes the host keeps data-before-command order on the link
`timescale 1ns/100ps
module ring_counter_compare_unit
   import ring_compare_pkg::*;
(
   // register link
   ring_link_if.device link,
   // motion inputs
   input wire logic logical_up,
   input wire logic logical_down,
   input wire logic encoder_up,
   input wire logic encoder_down,
   input wire logic [31:0] current_drive_speed,
   input wire logic [31:0] current_timer_value,
   // synchronous action save path
   input wire logic [3:0] save_strobe,
   input wire logic [31:0] save_value,
   // outputs
   output logic [3:0][31:0] compare_registers,
   output logic [31:0] logical_position_count,
   output logic [31:0] real_position_count,
   output logic [3:0] sync_action_sets,
   output logic [3:0] shared_compare_pins,
   output logic [3:0] shared_compare_pins_oe
);
   logic [15:0] data_low_reg;
   logic [15:0] data_high_reg;
   logic [31:0] logical_ring_max_reg;
   logic [31:0] real_ring_max_reg;
   logic [15:0] compare_mode_reg;
   logic [15:0] pin_function_reg;
   logic [3:0] interrupt_enable_reg;
   logic [3:0] result_next;
   logic [3:0] rise;
   logic cmd_strobe;
   logic [7:0] cmd_code;
   logic [31:0] cmd_word;
   logic max_in_range;

   // a command executes on the link cycle that carries its code
   assign cmd_strobe = link.wr_en && (link.wr_sel == `SEL_COMMAND);
   assign cmd_code = link.wr_data[7:0];
   assign cmd_word = {data_high_reg, data_low_reg};
   // negative values would break the wrap compare, so they are dropped
   assign max_in_range = (cmd_word >= `RING_MAX_LOWEST) &&
      (cmd_word <= `RING_MAX_HIGHEST);

   // data staging registers, filled ahead of the command code
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         data_low_reg <= 16'h0000;
         data_high_reg <= 16'h0000;
      end else if (link.wr_en && link.wr_sel == `SEL_DATA_LOW) begin
         data_low_reg <= link.wr_data;
      end else if (link.wr_en && link.wr_sel == `SEL_DATA_HIGH) begin
         data_high_reg <= link.wr_data;
      end
   end

   // ring maxima
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         logical_ring_max_reg <= `RING_MAX_RESET;
         real_ring_max_reg <= `RING_MAX_RESET;
      end else if (cmd_strobe && max_in_range) begin
         if (cmd_code == `CMD_WR_LOGICAL_MAX) begin
            logical_ring_max_reg <= cmd_word;
         end
         if (cmd_code == `CMD_WR_REAL_MAX) begin
            real_ring_max_reg <= cmd_word;
         end
      end
   end

   // next value of a ring counter for one up or down step
   function automatic logic [31:0] ring_step(
      input logic [31:0] count,
      input logic [31:0] ring_max,
      input logic up,
      input logic down
   );
      logic [31:0] value;
      value = count;
      if (up && !down) begin
         value = (count == ring_max) ? 32'h00000000 :
            count + 32'h00000001;
      end else if (down && !up) begin
         value = (count == 32'h00000000) ? ring_max :
            count - 32'h00000001;
      end
      return value;
   endfunction : ring_step

   // logical counter follows output pulses; a host write wins
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         logical_position_count <= 32'h00000000;
      end else if (cmd_strobe && cmd_code == `CMD_WR_LOGICAL_COUNT) begin
         logical_position_count <= cmd_word;
      end else begin
         logical_position_count <= ring_step(logical_position_count,
            logical_ring_max_reg, logical_up, logical_down);
      end
   end

   // real counter follows the encoder; wraps at all ones by default
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         real_position_count <= 32'h00000000;
      end else if (cmd_strobe && cmd_code == `CMD_WR_REAL_COUNT) begin
         real_position_count <= cmd_word;
      end else begin
         real_position_count <= ring_step(real_position_count,
            real_ring_max_reg, encoder_up, encoder_down);
      end
   end

   // compare mode, pin function and interrupt enable settings
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         compare_mode_reg <= 16'h0000;
         pin_function_reg <= 16'h0000;
         interrupt_enable_reg <= 4'h0;
      end else begin
         if (cmd_strobe && cmd_code == `CMD_WR_COMPARE_MODE) begin
            compare_mode_reg <= data_low_reg;
         end
         if (cmd_strobe && cmd_code == `CMD_WR_PIN_FUNCTION) begin
            pin_function_reg <= data_low_reg;
         end
         if (link.wr_en && link.wr_sel == `SEL_IRQ_ENABLE) begin
            interrupt_enable_reg <= link.wr_data[3:0];
         end
      end
   end

   // per-channel storage, compare and edge logic
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_channel
         logic [1:0] object_sel;
         logic [1:0] cond_sel;
         logic [31:0] object_value;
         logic signed [31:0] obj_s;
         logic signed [31:0] ref_s;
         assign object_sel = compare_mode_reg[4*k+1 : 4*k];
         assign cond_sel = compare_mode_reg[4*k+3 : 4*k+2];

         // storage has no reset; software loads it before use
         always_ff @(posedge link.clock) begin
            if (cmd_strobe && cmd_code == `CMD_WR_COMPARE_BASE + 8'(k)) begin
               compare_registers[k] <= cmd_word;
            end else if (save_strobe[k]) begin
               compare_registers[k] <= save_value;
            end
         end

         // object select
         always_comb begin
            case (object_sel)
               2'h0: object_value = logical_position_count;
               2'h1: object_value = real_position_count;
               2'h2: object_value = current_drive_speed;
               2'h3: object_value = current_timer_value;
               default: object_value = logical_position_count;
            endcase
         end

         assign obj_s = signed'(object_value);
         assign ref_s = signed'(compare_registers[k]);

         // condition select on signed values
         always_comb begin
            case (cond_sel)
               2'h0: result_next[k] = (obj_s >= ref_s);
               2'h1: result_next[k] = (obj_s > ref_s);
               2'h2: result_next[k] = (obj_s == ref_s);
               2'h3: result_next[k] = (obj_s < ref_s);
               default: result_next[k] = 1'b0;
            endcase
         end

         // only a false-to-true change counts as an event
         assign rise[k] = result_next[k] && !link.compare_status[k];

         // pin k+4 carries result k only when set to compare output
         always_ff @(posedge link.clock) begin
            if (link.rst) begin
               shared_compare_pins[k] <= 1'b0;
               shared_compare_pins_oe[k] <= 1'b0;
            end else begin
               shared_compare_pins_oe[k] <=
                  (pin_function_reg[2*k+9 : 2*k+8] == `PIN_FIELD_COMPARE);
               shared_compare_pins[k] <= result_next[k] &&
                  (pin_function_reg[2*k+9 : 2*k+8] ==
                   `PIN_FIELD_COMPARE);
            end
         end
      end
   endgenerate

   // results registered every cycle, so status is one cycle behind
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         link.compare_status <= 4'h0;
         sync_action_sets <= 4'h0;
      end else begin
         link.compare_status <= result_next;
         sync_action_sets <= rise;
      end
   end

   // sticky flags; enable gates the edge, so a result already true
   // stays silent; an edge beats a clear in the same cycle
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         link.irq_flags <= 4'h0;
         link.irq <= 1'b0;
      end else begin
         if (link.wr_en && link.wr_sel == `SEL_IRQ_ENABLE) begin
            link.irq_flags <= (link.irq_flags & ~link.wr_data[7:4]) |
               (rise & interrupt_enable_reg);
         end else begin
            link.irq_flags <= link.irq_flags |
               (rise & interrupt_enable_reg);
         end
         link.irq <= |(link.irq_flags | (rise & interrupt_enable_reg));
      end
   end

   // read commands latch their answer for the host
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         link.rd_data <= 32'h00000000;
      end else if (cmd_strobe) begin
         case (cmd_code)
            `CMD_RD_LOGICAL_COUNT: link.rd_data <= logical_position_count;
            `CMD_RD_REAL_COUNT: link.rd_data <= real_position_count;
            `CMD_RD_COMPARE_BASE, `CMD_RD_COMPARE_BASE + 8'h01,
            `CMD_RD_COMPARE_BASE + 8'h02, `CMD_RD_COMPARE_BASE + 8'h03:
               link.rd_data <= compare_registers[cmd_code[1:0]];
            `CMD_RD_COMPARE_MODE:
               link.rd_data <= {16'h0000, compare_mode_reg};
            default: ;
         endcase
      end
   end
endmodule : ring_counter_compare_unit

// ### rtl/ring_compare_params.svh
// constants of the ring compare unit and its host end
// assumes inclusion by bare name from the package
// Summary of operation
// - position counters are 32-bit wrapping up/down counters
// - counters wrap between zero and programmed maximum
// - ring maximum accepted only from 1 to 7fffffff
// - commands 0eh and 0fh load ring maxima
// - both ring maxima reset to all ones
// - software writes counters only within ring range
// - four signed 32-bit compare registers per axis
// - commands 10h-13h write, 34h-37h read compares
// - compare registers are not reset
// - command 20h loads modes, 40h reads them
// - object field picks logical, real, speed, timer
// - condition field picks ge, gt, eq, lt
// - speed equality unsafe above 400000h acceleration
// - compare results readable as status bits
// - compare pin high exactly while result true
// - results 0-3 drive pins 4-7 when field 11
// - rising result triggers its sync action once
// - rising result raises its interrupt request
// - sync actions load from or save into compares
// - data registers written before the command code
// - logical counts output pulses, real counts encoder
// - already-true result gives no interrupt on enable
`ifndef RING_COMPARE_PARAMS_SVH
`define RING_COMPARE_PARAMS_SVH

// link write selects
`define SEL_COMMAND 2'h0
`define SEL_IRQ_ENABLE 2'h1
`define SEL_DATA_LOW 2'h2
`define SEL_DATA_HIGH 2'h3

// command codes
`define CMD_WR_LOGICAL_COUNT 8'h00
`define CMD_WR_REAL_COUNT 8'h01
`define CMD_WR_LOGICAL_MAX 8'h0e
`define CMD_WR_REAL_MAX 8'h0f
`define CMD_WR_COMPARE_BASE 8'h10
`define CMD_WR_COMPARE_MODE 8'h20
`define CMD_WR_PIN_FUNCTION 8'h21
`define CMD_RD_LOGICAL_COUNT 8'h30
`define CMD_RD_REAL_COUNT 8'h31
`define CMD_RD_COMPARE_BASE 8'h34
`define CMD_RD_COMPARE_MODE 8'h40

// ring limits, reset values and compare pin field code
`define RING_MAX_RESET 32'hffffffff
`define RING_MAX_LOWEST 32'h00000001
`define RING_MAX_HIGHEST 32'h7fffffff
`define PIN_FIELD_COMPARE 2'h3

// bus byte offsets
`define ADDR_COMMAND 8'h00
`define ADDR_DATA_LOW 8'h04
`define ADDR_DATA_HIGH 8'h08
`define ADDR_IRQ_ENABLE 8'h0c
`define ADDR_READ_DATA 8'h10
`define ADDR_STATUS 8'h14

// status word bit positions
`define STATUS_COMPARE_LSB 0
`define STATUS_FLAGS_LSB 4
`define STATUS_IRQ_BIT 8
`define STATUS_BUSY_BIT 9

`endif

// ### rtl/ring_compare_pkg.sv
// types shared by both ends of the ring compare unit
// assumes the constants header sits beside it
package ring_compare_pkg;
`include "ring_compare_params.svh"

   // host sequencer states, gray along idle-high-low-command
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_send_high = 3'b001,
      st_send_low = 3'b011,
      st_send_cmd = 3'b010,
      st_send_enable = 3'b110
   } host_state_t;

   typedef logic [31:0] word_t;
endpackage : ring_compare_pkg

// ### rtl/ring_link_if.sv
// register link between the host end and the compare unit
// assumes one shared clock and synchronous reset
`timescale 1ns/100ps
interface ring_link_if (
   input wire logic clock,
   input wire logic rst
);
   logic wr_en;
   logic [1:0] wr_sel;
   logic [15:0] wr_data;
   logic [31:0] rd_data;
   logic [3:0] compare_status;
   logic [3:0] irq_flags;
   logic irq;

   modport device (
      input clock, rst, wr_en, wr_sel, wr_data,
      output rd_data, compare_status, irq_flags, irq
   );
   modport host (
      input clock, rst, rd_data, compare_status, irq_flags, irq,
      output wr_en, wr_sel, wr_data
   );
endinterface : ring_link_if

// ### rtl/ring_compare_host.sv
// host end: ahb-lite slave registers that drive the register link
// assumes a single ahb-lite master issuing word transfers
`timescale 1ns/100ps
module ring_compare_host
   import ring_compare_pkg::*;
(
   // register link
   ring_link_if.host link,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // interrupt to the processor
   output logic irq
);
   host_state_t state_reg;
   logic [15:0] data_low_reg;
   logic [15:0] data_high_reg;
   logic [7:0] command_reg;
   logic [7:0] irq_enable_reg;
   logic wr_phase_reg;
   logic [7:0] wr_addr_reg;
   logic addr_take;
   logic busy;

   assign addr_take = hsel && htrans[1] && hready;
   assign busy = (state_reg != st_idle);

   // bus response: zero wait states, always okay
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         irq <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= link.irq;
      end
   end

   // address phase capture for writes
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         wr_phase_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_phase_reg <= addr_take && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // read data is latched at the address phase
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         hrdata <= 32'h00000000;
      end else if (addr_take && !hwrite) begin
         case (haddr[7:0])
            `ADDR_DATA_LOW: hrdata <= {16'h0000, data_low_reg};
            `ADDR_DATA_HIGH: hrdata <= {16'h0000, data_high_reg};
            `ADDR_IRQ_ENABLE: hrdata <= {24'h000000, irq_enable_reg};
            `ADDR_READ_DATA: hrdata <= link.rd_data;
            `ADDR_STATUS: hrdata <= {22'h0, busy, link.irq,
               link.irq_flags, link.compare_status};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // software registers; writes dropped while busy
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         data_low_reg <= 16'h0000;
         data_high_reg <= 16'h0000;
         command_reg <= 8'h00;
         irq_enable_reg <= 8'h00;
      end else if (wr_phase_reg && !busy) begin
         case (wr_addr_reg)
            `ADDR_DATA_LOW: data_low_reg <= hwdata[15:0];
            `ADDR_DATA_HIGH: data_high_reg <= hwdata[15:0];
            `ADDR_COMMAND: command_reg <= hwdata[7:0];
            `ADDR_IRQ_ENABLE: irq_enable_reg <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // sequencer: high data, low data, then the command code
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         state_reg <= st_idle;
      end else begin
         case (state_reg)
            st_idle: begin
               if (wr_phase_reg && wr_addr_reg == `ADDR_COMMAND) begin
                  state_reg <= st_send_high;
               end else if (wr_phase_reg &&
                  wr_addr_reg == `ADDR_IRQ_ENABLE) begin
                  state_reg <= st_send_enable;
               end
            end
            st_send_high: state_reg <= st_send_low;
            st_send_low: state_reg <= st_send_cmd;
            st_send_cmd: state_reg <= st_idle;
            st_send_enable: state_reg <= st_idle;
            default: state_reg <= st_idle;
         endcase
      end
   end

   // link drive, one beat per busy sequencer state
   always_ff @(posedge link.clock) begin
      if (link.rst) begin
         link.wr_en <= 1'b0;
         link.wr_sel <= `SEL_COMMAND;
         link.wr_data <= 16'h0000;
      end else begin
         link.wr_en <= busy;
         case (state_reg)
            st_send_high: begin
               link.wr_sel <= `SEL_DATA_HIGH;
               link.wr_data <= data_high_reg;
            end
            st_send_low: begin
               link.wr_sel <= `SEL_DATA_LOW;
               link.wr_data <= data_low_reg;
            end
            st_send_cmd: begin
               link.wr_sel <= `SEL_COMMAND;
               link.wr_data <= {8'h00, command_reg};
            end
            st_send_enable: begin
               link.wr_sel <= `SEL_IRQ_ENABLE;
               link.wr_data <= {8'h00, irq_enable_reg};
            end
            default: begin
               link.wr_sel <= `SEL_COMMAND;
               link.wr_data <= 16'h0000;
            end
         endcase
      end
   end
endmodule : ring_compare_host

// ### verif/ring_compare_asserts.sv
// link checker for the ring compare unit and its host end
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module ring_compare_asserts
   import ring_compare_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // link signals
   input wire logic wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic [31:0] rd_data,
   input wire logic [3:0] compare_status,
   input wire logic [3:0] irq_flags,
   input wire logic irq
);
   logic [3:0] en_reg, flags_reg, status_reg, flag_rise, status_rise;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // mirror of the enable beats
   always_ff @(posedge clock) begin
      if (rst) begin
         en_reg <= 4'h0;
      end else if (wr_en && wr_sel == 2'h1) begin
         en_reg <= wr_data[3:0];
      end
   end

   // last cycle's flags and results; enable masks keep unknown
   // results of unloaded compares out
   always_ff @(posedge clock) begin
      flags_reg <= irq_flags;
      status_reg <= compare_status;
   end
   assign flag_rise = irq_flags & ~flags_reg;
   assign status_rise = compare_status & ~status_reg;

   sequence low_beat;
      wr_en && wr_sel == 2'h2;
   endsequence
   sequence cmd_beat;
      wr_en && wr_sel == 2'h0;
   endsequence

   AST_BEAT_ORDER: assert property (
      wr_en && wr_sel == 2'h3 |=> low_beat ##1 cmd_beat ##1 !wr_en)
      else $error("bad link beat order");
   AST_CMD_AFTER_LOW: assert property (
      cmd_beat |-> $past(wr_en) && $past(wr_sel) == 2'h2)
      else $error("command without low beat");
   AST_IRQ_ANY: assert property (
      irq == |(irq_flags | flags_reg))
      else $error("irq does not follow the flags");
   AST_FLAG_ON_RISE: assert property (
      (flag_rise & ~status_rise) == 4'h0)
      else $error("flag set without a rising result");
   AST_FLAG_ENABLED: assert property (
      (flag_rise & ~$past(en_reg)) == 4'h0)
      else $error("flag set while disabled");
   AST_RISE_SETS_FLAG: assert property (
      (status_rise & $past(en_reg) & ~irq_flags) == 4'h0)
      else $error("enabled rise left flag clear");
   AST_FLAG_STICKY: assert property (
      (flags_reg & ~irq_flags) != 4'h0 |->
         $past(wr_en) && $past(wr_sel) == 2'h1)
      else $error("flag cleared without a clear beat");
   AST_RD_ON_CMD: assert property (
      $changed(rd_data) |-> $past(wr_en) && $past(wr_sel) == 2'h0)
      else $error("read data moved without a command");
endmodule : ring_compare_asserts

// ### verif/testbench.sv
// self-checking bench: host end and compare unit joined by the link
// assumes it is the only ahb master and drives motion inputs
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("[ERR] %s exp %h seen %h", what, exp, got); \
      end \
   end

module testbench;
   import ring_compare_pkg::*;
   logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr;
   word_t hwdata, hrdata, speed, timer, save_value, lp, rp, q;
   logic l_up, l_dn, e_up, e_dn;
   logic [3:0] save_strobe, sync_sets, pins, pins_oe;
   logic [3:0][31:0] cmp_regs;
   int checks = 0;
   int miscompares = 0;
   int sync_count;

   ring_link_if link (.clock(clock), .rst(rst));
   ring_compare_host i_ring_compare_host (.link(link), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   ring_counter_compare_unit i_ring_counter_compare_unit (.link(link),
      .logical_up(l_up), .logical_down(l_dn), .encoder_up(e_up),
      .encoder_down(e_dn), .current_drive_speed(speed),
      .current_timer_value(timer), .save_strobe(save_strobe),
      .save_value(save_value), .compare_registers(cmp_regs),
      .logical_position_count(lp), .real_position_count(rp),
      .sync_action_sets(sync_sets), .shared_compare_pins(pins),
      .shared_compare_pins_oe(pins_oe));
   ring_compare_asserts i_ring_compare_asserts (.clock(clock),
      .rst(rst), .wr_en(link.wr_en), .wr_sel(link.wr_sel),
      .wr_data(link.wr_data), .rd_data(link.rd_data),
      .compare_status(link.compare_status),
      .irq_flags(link.irq_flags), .irq(link.irq));

   // the one slave's ready is the bus ready
   assign hready = hreadyout;

   // 125 mhz clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // count sync set 0 pulses; unknowns are not counted
   always @(posedge clock) begin
      if (rst) begin
         sync_count <= 0;
      end else if (sync_sets[0] === 1'b1) begin
         sync_count <= sync_count + 1;
      end
   end

   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // bounded wait for an edge with hready high
   task automatic wait_ready(inout int n);
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (n >= 64) begin
         miscompares++;
         report_and_stop();
      end
   endtask : wait_ready

   // single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [7:0] a,
         input word_t d, output word_t r);
      int n = 0;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_ready(n);
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready(n);
      r = hrdata;
   endtask : xfer

   task automatic rd(input logic [7:0] a, output word_t r);
      xfer(1'b0, a, 32'h0, r);
   endtask : rd

   // writes are dropped while busy, so poll busy away
   task automatic wr(input logic [7:0] a, input word_t d);
      word_t s;
      int n = 0;
      xfer(1'b1, a, d, s);
      do begin
         rd(8'h14, s);
         n++;
      end while (s[9] !== 1'b0 && n < 32);
      if (n >= 32) begin
         miscompares++;
         report_and_stop();
      end
   endtask : wr

   task automatic cmd(input logic [7:0] c, input word_t v);
      wr(8'h08, {16'h0, v[31:16]});
      wr(8'h04, {16'h0, v[15:0]});
      wr(8'h00, {24'h0, c});
   endtask : cmd

   task automatic rcmd(input logic [7:0] c, output word_t r);
      cmd(c, 32'h0);
      rd(8'h10, r);
   endtask : rcmd

   // one cycle of {enc down, enc up, log down, log up}
   task automatic step(input logic [3:0] p);
      {e_dn, e_up, l_dn, l_up} <= p;
      @(posedge clock);
      {e_dn, e_up, l_dn, l_up} <= 4'h0;
      repeat (2) @(posedge clock);
   endtask : step

   task automatic test_ring_default;
      `CHECK("oe", 4'h0, pins_oe)
      step(4'b0010);
      `CHECK("lp", 32'hffffffff, lp)
      step(4'b0001);
      `CHECK("lp", 32'h0, lp)
      step(4'b1000);
      `CHECK("rp", 32'hffffffff, rp)
      step(4'b0111);
      `CHECK("rp", 32'h0, rp)
      `CHECK("lp", 32'h0, lp)
      rd(8'h1c, q);
      `CHECK("unmapped", 32'h0, q)
      `CHECK("hresp", 1'b0, hresp)
      $display("test ring_default done");
   endtask : test_ring_default

   task automatic test_ring_max;
      cmd(8'h0e, 32'h0000270f);
      cmd(8'h0e, 32'hffffffff);
      cmd(8'h0f, 32'h00000000);
      cmd(8'h0f, 32'h00000001);
      step(4'b0010);
      `CHECK("lp", 32'h270f, lp)
      step(4'b0001);
      `CHECK("lp", 32'h0, lp)
      step(4'b0100);
      step(4'b0100);
      `CHECK("rp", 32'h0, rp)
      step(4'b1000);
      rcmd(8'h31, q);
      `CHECK("rp read", 32'h1, q)
      cmd(8'h0e, 32'h7fffffff);
      cmd(8'h0f, 32'h7fffffff);
      step(4'b0010);
      `CHECK("lp", 32'h7fffffff, lp)
      step(4'b0001);
      `CHECK("lp", 32'h0, lp)
      $display("test ring_max done");
   endtask : test_ring_max

   task automatic test_registers;
      for (int k = 0; k < 4; k++) begin
         cmd(8'h10 + 8'(k), 32'h87654321 ^ 32'(k));
      end
      for (int k = 0; k < 4; k++) begin
         rcmd(8'h34 + 8'(k), q);
         `CHECK("cmp rd", 32'h87654321 ^ 32'(k), q)
         `CHECK("cmp", 32'h87654321 ^ 32'(k), cmp_regs[k])
      end
      cmd(8'h20, 32'h0000a5c3);
      rcmd(8'h40, q);
      `CHECK("mode", 16'ha5c3, q[15:0])
      save_value <= 32'h13572468;
      save_strobe <= 4'h4;
      @(posedge clock);
      save_strobe <= 4'h0;
      repeat (2) @(posedge clock);
      `CHECK("saved", 32'h13572468, cmp_regs[2])
      $display("test registers done");
   endtask : test_registers

   // only object o holds 100, so only the right source matches
   task automatic test_objects;
      for (int k = 0; k < 4; k++) begin
         cmd(8'h10 + 8'(k), 32'd100);
      end
      for (int o = 0; o < 4; o++) begin
         cmd(8'h20, {16'h0, {4{2'b10, 2'(o)}}});
         cmd(8'h00, (o == 0) ? 32'd100 : 32'd0);
         cmd(8'h01, (o == 1) ? 32'd100 : 32'd0);
         speed <= (o == 2) ? 32'd100 : 32'd0;
         timer <= (o == 3) ? 32'd100 : 32'd0;
         repeat (2) @(posedge clock);
         rd(8'h14, q);
         `CHECK("object", 4'hf, q[3:0])
      end
      $display("test objects done");
   endtask : test_objects

   task automatic test_conditions;
      word_t obj [4] = '{32'd99, 32'd100, 32'd101, 32'hffffffff};
      logic [3:0] want [4] = '{4'h8, 4'h5, 4'h3, 4'h8};
      cmd(8'h20, 32'h0000fb73);
      cmd(8'h21, 32'h00000c00);
      @(posedge clock);
      `CHECK("oe", 4'h2, pins_oe)
      cmd(8'h21, 32'h0000ff00);
      for (int i = 0; i < 4; i++) begin
         timer <= obj[i];
         repeat (2) @(posedge clock);
         rd(8'h14, q);
         `CHECK("status", want[i], q[3:0])
         `CHECK("pins", want[i], pins)
         `CHECK("oe", 4'hf, pins_oe)
      end
      $display("test conditions done");
   endtask : test_conditions

   task automatic test_events;
      int base;
      cmd(8'h20, 32'h00000003);
      timer <= 32'd200;
      repeat (3) @(posedge clock);
      base = sync_count;
      wr(8'h0c, 32'h00000001);
      timer <= 32'd300;
      repeat (3) @(posedge clock);
      rd(8'h14, q);
      `CHECK("flags", 4'h0, q[7:4])
      `CHECK("sync", base, sync_count)
      timer <= 32'd50;
      repeat (3) @(posedge clock);
      timer <= 32'd200;
      repeat (3) @(posedge clock);
      rd(8'h14, q);
      `CHECK("flags", 4'h1, q[7:4])
      `CHECK("irq", 1'b1, irq)
      `CHECK("sync", base + 1, sync_count)
      wr(8'h0c, 32'h00000011);
      rd(8'h14, q);
      `CHECK("flags", 4'h0, q[7:4])
      @(posedge clock);
      `CHECK("irq", 1'b0, irq)
      $display("test events done");
   endtask : test_events

   // main sequence; hsel and hsize stay fixed
   initial begin
      rst = 1'b1;
      hsel = 1'b1;
      hsize = 3'h2;
      {htrans, hwrite, haddr, hwdata} = 67'h0;
      {speed, timer, save_value} = 96'h0;
      {e_dn, e_up, l_dn, l_up, save_strobe} = 8'h0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      test_ring_default();
      test_ring_max();
      test_registers();
      test_objects();
      test_conditions();
      test_events();
      report_and_stop();
   end
endmodule : testbench
